// File: core/mpss_consts.svh
`ifndef MPSS_CONSTS_SVH
`define MPSS_CONSTS_SVH

// apb register byte offsets
`define MPSS_CTRL_OFS       12'h000
`define MPSS_VCODE_OFS      12'h004
`define MPSS_STATUS_OFS     12'h008
`define MPSS_RAMP_OFS       12'h00c
`define MPSS_PHDIV_OFS      12'h010
// ctrl field positions
`define MPSS_CTRL_EN_BIT    0
`define MPSS_CTRL_POR_BIT   1
// reset values
`define MPSS_CTRL_RST       2'h0
`define MPSS_VCODE_RST      5'h1f
`define MPSS_PHDIV_RST      16'h0018
// timing counts in phase clock pulses, plus the overcurrent retry limit
`define MPSS_SS_PULSES      2048
`define MPSS_WAIT_PULSES    2048
`define MPSS_MAX_RETRIES    7
`define MPSS_STEP_PULSES    2
// shutdown voltage code
`define MPSS_VCODE_OFF      5'h1f
// ramp top is 140 percent of reference
`define MPSS_RAMP_NUM       14
`define MPSS_RAMP_DEN       10

`endif

// File: core/mpss_pkg.sv
package mpss_pkg;
    typedef enum logic [2:0] {
        MPSS_SHUTDOWN,
        MPSS_SOFTSTART,
        MPSS_RUN,
        MPSS_HICCUP,
        MPSS_OV_LATCH,
        MPSS_OC_LATCH
    } mpss_state_t;
    // pwm pin drive mode
    typedef enum logic [1:0] {
        MPSS_PWM_HIZ,
        MPSS_PWM_LOW,
        MPSS_PWM_SWITCH
    } mpss_pwm_t;
endpackage : mpss_pkg

// File: core/mpss_sequencer.sv
`timescale 1ns/1ns
`include "mpss_consts.svh"

// Operation
// R1: shutdown keeps all pwm pins high impedance
// R2: start needs por, enable, non-off code
// R3: all-ones code means shutdown, else start
// R4: soft-start lasts 2048 phase pulses
// R5: ramp up to 140 percent, offset down
// R6: regulate to lower of ramp, reference
// R7: window ok low in shutdown, high at reference
// R8: window ok falls only on disable/fault
// R9: undervoltage drops window ok, keeps switching
// R10: disable holds window ok until undervoltage
// R11: overvoltage drops window ok, pwm low
// R12: pwm low until reference, then hiz, repeat
// R13: overvoltage latched until enable or por drop
// R14: overcurrent: hiz, window low, wait 2048
// R15: overcurrent active during soft-start too
// R16: seven retries, eighth failure latches off
// R17: latch-off left only via enable/por drop
// R18: good soft-start clears retry counter
// R19: blank overcurrent during code transition
// R20: step reference every two phase pulses
// R21: latched off keeps hiz, window low
module mpss_sequencer (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 overvoltage_fault,
    input  wire logic                 undervoltage_fault,
    input  wire logic                 at_reference,
    input  wire logic [3:0]           overcurrent_fault,
    output logic      [3:0]           pwm_out,
    output logic      [3:0]           pwm_oe,
    output logic                      output_window_ok_oe,
    output mpss_pkg::mpss_pwm_t       pwm_mode,
    output logic      [10:0]          softstart_ramp_level,
    output logic      [10:0]          softstart_offset_current,
    output logic      [4:0]           regulation_code,
    output logic                      regulate_to_ramp
);
    import mpss_pkg::*;

    localparam logic [10:0] SS_LAST   = 11'(`MPSS_SS_PULSES - 1);
    localparam logic [10:0] WAIT_LAST = 11'(`MPSS_WAIT_PULSES - 1);
    localparam logic [2:0]  RETRY_MAX = 3'(`MPSS_MAX_RETRIES);

    // apb-visible state
    logic [1:0]  ctrl;
    logic [4:0]  voltage_select_code;
    logic [15:0] phase_div;
    logic [1:0]  next_ctrl;
    logic [4:0]  next_code;
    logic [15:0] next_div;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // sequencer state
    mpss_state_t state;
    mpss_state_t next_state;
    logic [10:0] count;
    logic [10:0] next_count;
    logic [2:0]  retries;
    logic [2:0]  next_retries;
    logic [4:0]  ref_code;
    logic [4:0]  next_ref_code;
    logic        step_phase;
    logic        next_step_phase;
    logic        ov_pull;
    logic        next_ov_pull;
    logic        window_low;
    logic        next_window_low;
    logic        was_good;
    logic        next_was_good;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic        ph_tick;
    logic        next_ph_tick;
    mpss_pwm_t   next_pwm_mode;

    logic enabled;
    logic oc_seen;
    logic transition;
    logic bus_write;
    logic bus_read;

    assign bus_write = psel && penable && pwrite;
    assign bus_read  = psel && !penable && !pwrite;
    assign enabled   = ctrl[`MPSS_CTRL_EN_BIT] && ctrl[`MPSS_CTRL_POR_BIT]
                       && (voltage_select_code != `MPSS_VCODE_OFF); // R2 R3
    assign transition = (ref_code != voltage_select_code) && (state == MPSS_RUN);
    assign oc_seen    = (|overcurrent_fault) && !transition; // R15 R19

    // register writes and read data, zero-wait slave
    always_comb begin
        next_ctrl    = ctrl;
        next_code    = voltage_select_code;
        next_div     = phase_div;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (bus_write) begin
            if (paddr == `MPSS_CTRL_OFS) begin
                next_ctrl = pwdata[1:0];
            end else if (paddr == `MPSS_VCODE_OFS) begin
                next_code = pwdata[4:0];
            end else if (paddr == `MPSS_PHDIV_OFS) begin
                next_div = pwdata[15:0];
            end else if (paddr != `MPSS_STATUS_OFS && paddr != `MPSS_RAMP_OFS) begin
                next_pslverr = 1'b1;
            end
        end
        if (bus_read) begin
            next_prdata = 32'h0;
            if (paddr == `MPSS_CTRL_OFS) begin
                next_prdata = {30'h0, ctrl};
            end else if (paddr == `MPSS_VCODE_OFS) begin
                next_prdata = {27'h0, voltage_select_code};
            end else if (paddr == `MPSS_STATUS_OFS) begin
                next_prdata = {16'h0, 3'h0, ref_code, retries, output_window_ok_oe,
                               1'b0, state};
            end else if (paddr == `MPSS_RAMP_OFS) begin
                next_prdata = {5'h0, softstart_offset_current, 5'h0, softstart_ramp_level};
            end else if (paddr == `MPSS_PHDIV_OFS) begin
                next_prdata = {16'h0, phase_div};
            end
        end
        if (psel && !penable) begin
            next_pslverr = !(paddr == `MPSS_CTRL_OFS || paddr == `MPSS_VCODE_OFS
                             || paddr == `MPSS_STATUS_OFS || paddr == `MPSS_RAMP_OFS
                             || paddr == `MPSS_PHDIV_OFS);
            if (!next_pslverr) begin
                next_pslverr = 1'b0;
            end
        end else if (!bus_write) begin
            next_pslverr = pslverr && psel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                <= `MPSS_CTRL_RST;
            voltage_select_code <= `MPSS_VCODE_RST;
            phase_div           <= `MPSS_PHDIV_RST;
            prdata              <= 32'h0;
            pslverr             <= 1'b0;
            pready              <= 1'b1;
        end else begin
            ctrl                <= next_ctrl;
            voltage_select_code <= next_code;
            phase_div           <= next_div;
            prdata              <= next_prdata;
            pslverr             <= next_pslverr;
            pready              <= 1'b1;
        end
    end

    // phase clock enable from a divider of pclk
    always_comb begin
        next_div_cnt = div_cnt + 16'h1;
        next_ph_tick = 1'b0;
        if (div_cnt >= phase_div) begin
            next_div_cnt = 16'h0;
            next_ph_tick = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0;
            ph_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            ph_tick <= next_ph_tick;
        end
    end

    // main sequencer; ov and oc latches leave only through an enable or por drop
    always_comb begin
        next_state      = state;
        next_count      = count;
        next_retries    = retries;
        next_ref_code   = ref_code;
        next_step_phase = step_phase;
        next_ov_pull    = ov_pull;
        next_window_low = window_low;
        next_was_good   = was_good;
        case (state)
            MPSS_SHUTDOWN: begin
                next_window_low = 1'b1; // R7
                next_was_good   = 1'b0;
                next_ov_pull    = 1'b0;
                next_retries    = 3'h0;
                if (enabled) begin // R2
                    next_state    = MPSS_SOFTSTART;
                    next_count    = 11'h0;
                    next_ref_code = voltage_select_code;
                end
            end
            MPSS_SOFTSTART: begin
                if (at_reference) begin
                    next_window_low = 1'b0; // R7
                    next_was_good   = 1'b1;
                end
                if (ph_tick) begin
                    next_count = count + 11'h1; // R4
                end
                if (!enabled) begin
                    next_state = MPSS_SHUTDOWN;
                    next_window_low = 1'b1; // R7: no high window ok into shutdown
                end else if (overvoltage_fault) begin
                    next_state = MPSS_OV_LATCH;
                    next_ov_pull = 1'b1;
                    next_window_low = 1'b1;
                end else if (oc_seen) begin // R15
                    next_window_low = 1'b1;
                    next_count = 11'h0;
                    if (retries == RETRY_MAX) begin
                        next_state = MPSS_OC_LATCH; // R16
                    end else begin
                        next_state = MPSS_HICCUP;
                        next_retries = retries + 3'h1;
                    end
                end else if (ph_tick && count == SS_LAST) begin
                    next_state      = MPSS_RUN;
                    next_retries    = 3'h0; // R18
                    next_window_low = 1'b0;
                    next_was_good   = 1'b1;
                    next_step_phase = 1'b0;
                end
            end
            MPSS_RUN: begin
                // R20: one code step per two phase pulses
                if (ph_tick && ref_code != voltage_select_code) begin
                    next_step_phase = !step_phase;
                    if (step_phase) begin
                        next_ref_code = (ref_code < voltage_select_code)
                                        ? ref_code + 5'h1 : ref_code - 5'h1;
                    end
                end
                next_window_low = undervoltage_fault; // R9
                if (overvoltage_fault) begin // R11
                    next_state = MPSS_OV_LATCH;
                    next_ov_pull = 1'b1;
                    next_window_low = 1'b1;
                end else if (!enabled) begin
                    // R10: window ok falls only once output decays
                    if (undervoltage_fault) begin
                        next_state = MPSS_SHUTDOWN;
                        next_window_low = 1'b1;
                    end else begin
                        next_window_low = 1'b0;
                    end
                end else if (oc_seen) begin // R14
                    next_window_low = 1'b1;
                    next_count = 11'h0;
                    next_state = MPSS_HICCUP;
                    next_retries = retries + 3'h1;
                end
            end
            MPSS_HICCUP: begin
                next_window_low = 1'b1; // R14
                if (ph_tick) begin
                    next_count = count + 11'h1;
                end
                if (!enabled) begin
                    next_state = MPSS_SHUTDOWN;
                end else if (ph_tick && count == WAIT_LAST) begin
                    next_state    = MPSS_SOFTSTART;
                    next_count    = 11'h0;
                    next_ref_code = voltage_select_code;
                end
            end
            MPSS_OV_LATCH: begin
                next_window_low = 1'b1; // R13
                if (overvoltage_fault) begin
                    next_ov_pull = 1'b1; // R12
                end else if (!at_reference) begin // pull released once at_reference is low
                    next_ov_pull = 1'b0;
                end
                if (!(ctrl[`MPSS_CTRL_EN_BIT] && ctrl[`MPSS_CTRL_POR_BIT])) begin
                    next_state = MPSS_SHUTDOWN; // R13
                end
            end
            MPSS_OC_LATCH: begin
                next_window_low = 1'b1; // R21
                if (!(ctrl[`MPSS_CTRL_EN_BIT] && ctrl[`MPSS_CTRL_POR_BIT])) begin
                    next_state = MPSS_SHUTDOWN; // R17
                end
            end
            default: begin
                next_state = MPSS_SHUTDOWN;
            end
        endcase
        // once good, staying in soft-start keeps window ok up even if at_reference dips
        if (was_good && state == MPSS_SOFTSTART
            && next_state == MPSS_SOFTSTART) begin
            next_window_low = 1'b0; // R8
        end
    end

    // pwm pin mode per state
    always_comb begin
        next_pwm_mode = MPSS_PWM_HIZ; // R1 R21
        if (next_state == MPSS_SOFTSTART || next_state == MPSS_RUN) begin
            next_pwm_mode = MPSS_PWM_SWITCH;
        end else if (next_state == MPSS_OV_LATCH && next_ov_pull) begin
            next_pwm_mode = MPSS_PWM_LOW; // R11 R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state               <= MPSS_SHUTDOWN;
            count               <= 11'h0;
            retries             <= 3'h0;
            ref_code            <= `MPSS_VCODE_RST;
            step_phase          <= 1'b0;
            ov_pull             <= 1'b0;
            window_low          <= 1'b1;
            was_good            <= 1'b0;
            pwm_mode            <= MPSS_PWM_HIZ;
            output_window_ok_oe <= 1'b1;
            pwm_out             <= 4'h0;
            pwm_oe              <= 4'h0;
        end else begin
            state               <= next_state;
            count               <= next_count;
            retries             <= next_retries;
            ref_code            <= next_ref_code;
            step_phase          <= next_step_phase;
            ov_pull             <= next_ov_pull;
            window_low          <= next_window_low;
            was_good            <= next_was_good;
            pwm_mode            <= next_pwm_mode;
            output_window_ok_oe <= next_window_low; // open drain, oe pulls low
            pwm_out             <= 4'h0; // switching data comes from the analog path
            pwm_oe              <= (next_pwm_mode == MPSS_PWM_HIZ) ? 4'h0 : 4'hf;
        end
    end

    // ramp outputs: ramp rises, offset falls over soft-start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            softstart_ramp_level     <= 11'h0;
            softstart_offset_current <= 11'h7ff;
            regulation_code          <= `MPSS_VCODE_RST;
            regulate_to_ramp         <= 1'b0;
        end else begin
            softstart_ramp_level     <= (next_state == MPSS_SOFTSTART) ? next_count
                                        : ((next_state == MPSS_RUN) ? SS_LAST : 11'h0); // R5
            softstart_offset_current <= (next_state == MPSS_SOFTSTART) ? ~next_count
                                        : ((next_state == MPSS_RUN) ? 11'h0 : 11'h7ff); // R5
            regulation_code          <= next_ref_code;
            // R6: ramp full scale is 1.4 x ref, so ramp wins below ref
            regulate_to_ramp         <= (next_state == MPSS_SOFTSTART)
                && (15'(next_count) * 15'(`MPSS_RAMP_NUM)
                    < 15'(SS_LAST) * 15'(`MPSS_RAMP_DEN));
        end
    end

    a_shutdown_hiz: assert property (@(posedge pclk) disable iff (!presetn) // R1 R7
        state == MPSS_SHUTDOWN |-> pwm_oe == 4'h0 && output_window_ok_oe)
        else $error("pwm driven or window ok high in shutdown");
    a_start_needs: assert property (@(posedge pclk) disable iff (!presetn) // R2
        state == MPSS_SHUTDOWN && $past(state) == MPSS_SHUTDOWN ##1 state == MPSS_SOFTSTART
        |-> $past(voltage_select_code) != `MPSS_VCODE_OFF)
        else $error("start with off code");
    a_ov_low: assert property (@(posedge pclk) disable iff (!presetn) // R11
        state == MPSS_RUN && overvoltage_fault |=> output_window_ok_oe && pwm_oe == 4'hf)
        else $error("ov not handled");
    a_ov_stays: assert property (@(posedge pclk) disable iff (!presetn) // R13
        state == MPSS_OV_LATCH && ctrl == 2'h3 |=> state == MPSS_OV_LATCH)
        else $error("ov latch left");
    a_oc_latch: assert property (@(posedge pclk) disable iff (!presetn) // R21
        state == MPSS_OC_LATCH |-> output_window_ok_oe && pwm_oe == 4'h0)
        else $error("latched off not quiet");
    a_oc_hold: assert property (@(posedge pclk) disable iff (!presetn) // R17
        state == MPSS_OC_LATCH && ctrl == 2'h3 |=> state == MPSS_OC_LATCH)
        else $error("oc latch left");
    a_hiccup_hiz: assert property (@(posedge pclk) disable iff (!presetn) // R14
        state == MPSS_HICCUP |-> pwm_oe == 4'h0 && output_window_ok_oe)
        else $error("hiccup drives");
    a_retry_clear: assert property (@(posedge pclk) disable iff (!presetn) // R18
        $past(state) == MPSS_SOFTSTART && state == MPSS_RUN |-> retries == 3'h0)
        else $error("retries kept");
    a_blank_oc: assert property (@(posedge pclk) disable iff (!presetn) // R19
        state == MPSS_RUN && transition && enabled && !overvoltage_fault
        |=> state == MPSS_RUN)
        else $error("oc not blanked");
endmodule : mpss_sequencer

// File: tb/mpss_power_stage.sv
`timescale 1ns/1ns

// behavioural driver pair per phase plus the system monitor's pull-up
module mpss_power_stage (
    input  wire logic [3:0] pwm_out,
    input  wire logic [3:0] pwm_oe,
    input  wire logic       output_window_ok_oe,
    output logic      [3:0] lower_on,
    output logic      [3:0] upper_on,
    output logic            output_window_ok
);
    // a floating pin sits mid-rail, so the driver keeps both switches off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lower_on[i] = pwm_oe[i] && !pwm_out[i];
            upper_on[i] = pwm_oe[i] && pwm_out[i];
        end
    end
    // open-drain line: the pull-up wins whenever nobody sinks it
    assign output_window_ok = !output_window_ok_oe;
endmodule : mpss_power_stage

// File: tb/mpss_sequencer_test.sv
`timescale 1ns/1ns
`include "mpss_consts.svh"

module mpss_sequencer_test;
    import mpss_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mpss_note_t;
    logic        pclk = 0, presetn, psel, penable, pwrite, pready, pslverr;
    logic        overvoltage_fault, undervoltage_fault, at_reference;
    logic        output_window_ok_oe, regulate_to_ramp, output_window_ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  overcurrent_fault, pwm_out, pwm_oe, lower_on, upper_on;
    logic [10:0] softstart_ramp_level, softstart_offset_current;
    logic [4:0]  regulation_code, nc;
    mpss_pwm_t   pwm_mode;
    mpss_note_t  q[$];
    int          failures = 0, num_checks = 0, n, d;

    mpss_sequencer mpss_sequencer_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .overvoltage_fault, .undervoltage_fault, .at_reference,
        .overcurrent_fault, .pwm_out, .pwm_oe, .output_window_ok_oe, .pwm_mode,
        .softstart_ramp_level, .softstart_offset_current, .regulation_code,
        .regulate_to_ramp
    );
    mpss_power_stage mpss_power_stage_i (
        .pwm_out, .pwm_oe, .output_window_ok_oe, .lower_on, .upper_on, .output_window_ok
    );

    always #5 pclk = ~pclk;

    task automatic chk(logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk

    // each read answer is matched with the oldest queued note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk(prdata & q[0].m, q[0].d & q[0].m);
            chk({31'h0, pslverr}, {31'h0, q[0].e});
            void'(q.pop_front());
        end
    end

    // one transfer; the extra edge at the end keeps setups from colliding
    task automatic apb(logic w, logic [11:0] a, logic [31:0] dt, logic [31:0] m = '1);
        int k;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        if (!w) q.push_back('{dt, m, a > 12'h010});
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        if (pready !== 1'b1) failures++;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb

    task automatic cyc(int c);
        repeat (c) @(posedge pclk);
    endtask : cyc

    task automatic st(mpss_state_t s);
        apb(0, `MPSS_STATUS_OFS, {29'h0, s}, 32'h7);
    endtask : st

    // bounded wait for a pin drive mode; n holds the edges spent
    task automatic wait_mode(mpss_pwm_t m);
        n = 0;
        while (pwm_mode !== m && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 5000) failures++;
    endtask : wait_mode

    task automatic up();
        apb(1, `MPSS_CTRL_OFS, 32'h3);
        cyc(2060);
    endtask : up

    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    initial begin
        void'($urandom(32'h85a221fc));
        presetn = 0;
        {psel, penable, pwrite, overvoltage_fault, undervoltage_fault, at_reference} = '0;
        paddr = '0;
        pwdata = '0;
        overcurrent_fault = '0;
        cyc(4);
        presetn <= 1;
        @(posedge pclk);
        chk({28'h0, pwm_oe}, 32'h0);
        chk({31'h0, output_window_ok}, 32'h0);
        apb(0, `MPSS_CTRL_OFS, {30'h0, `MPSS_CTRL_RST});
        apb(0, `MPSS_VCODE_OFS, {27'h0, `MPSS_VCODE_RST});
        apb(0, `MPSS_PHDIV_OFS, {16'h0, `MPSS_PHDIV_RST});
        apb(0, 12'h0f0, 32'h0, 32'h0);
        $display("test reset done");
        // phase tick every pclk keeps the long counts affordable
        apb(1, `MPSS_PHDIV_OFS, 32'h0);
        apb(1, `MPSS_CTRL_OFS, 32'h3);
        cyc(3);
        st(MPSS_SHUTDOWN);
        apb(1, `MPSS_CTRL_OFS, 32'h1);
        apb(1, `MPSS_VCODE_OFS, 32'h0a);
        cyc(3);
        st(MPSS_SHUTDOWN);
        apb(1, `MPSS_CTRL_OFS, 32'h3);
        st(MPSS_SOFTSTART);
        cyc(2);
        chk({31'h0, regulate_to_ramp}, 32'h1);
        chk({21'h0, softstart_offset_current}, {21'h0, ~softstart_ramp_level});
        n = softstart_ramp_level;
        @(posedge pclk);
        chk({21'h0, softstart_ramp_level}, 32'(n + 1));
        chk({31'h0, output_window_ok}, 32'h0);
        at_reference <= 1;
        cyc(3);
        chk({31'h0, output_window_ok}, 32'h1);
        cyc(2025);
        st(MPSS_SOFTSTART);
        cyc(20);
        st(MPSS_RUN);
        chk({21'h0, softstart_offset_current}, 32'h0);
        chk({31'h0, regulate_to_ramp}, 32'h0);
        chk({28'h0, pwm_oe}, 32'hf);
        $display("test startup done");
        // undervoltage only drops the window, switching goes on
        undervoltage_fault <= 1;
        cyc(3);
        chk({31'h0, output_window_ok}, 32'h0);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_SWITCH});
        undervoltage_fault <= 0;
        cyc(3);
        chk({31'h0, output_window_ok}, 32'h1);
        apb(1, `MPSS_CTRL_OFS, 32'h2);
        cyc(5);
        chk({31'h0, output_window_ok}, 32'h1);
        undervoltage_fault <= 1;
        cyc(3);
        chk({31'h0, output_window_ok}, 32'h0);
        cyc(2);
        chk({28'h0, pwm_oe}, 32'h0);
        undervoltage_fault <= 0;
        $display("test undervoltage done");
        up();
        overvoltage_fault <= 1;
        cyc(3);
        chk({23'h0, upper_on, lower_on, output_window_ok}, 32'h1e);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_LOW});
        overvoltage_fault <= 0;
        at_reference <= 0;
        cyc(3);
        chk({28'h0, pwm_oe}, 32'h0);
        overvoltage_fault <= 1;
        at_reference <= 1;
        cyc(3);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_LOW});
        overvoltage_fault <= 0;
        at_reference <= 0;
        cyc(3);
        at_reference <= 1;
        cyc(10);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_HIZ});
        chk({31'h0, output_window_ok}, 32'h0);
        st(MPSS_OV_LATCH);
        apb(1, `MPSS_CTRL_OFS, 32'h2);
        cyc(3);
        st(MPSS_SHUTDOWN);
        $display("test overvoltage done");
        // a trip pulse inside the reference stepping must be ignored
        up();
        d = 4 + $urandom % 16;
        nc = 5'h0a + 5'(d);
        apb(1, `MPSS_VCODE_OFS, {27'h0, nc});
        n = 0;
        while (regulation_code !== nc && n < 100) begin
            overcurrent_fault <= (n == 2 || n == 3) ? 4'h1 << ($urandom % 4) : 4'h0;
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= 2 * d - 3 && n <= 2 * d + 4), 32'h1);
        cyc(3);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_SWITCH});
        overcurrent_fault <= 4'h8;
        cyc(3);
        chk({27'h0, pwm_oe, output_window_ok}, 32'h0);
        overcurrent_fault <= 4'h0;
        wait_mode(MPSS_PWM_SWITCH);
        chk(32'(n >= 2043 && n <= 2053), 32'h1);
        cyc(5);
        overcurrent_fault <= 4'h1 << ($urandom % 4);
        cyc(3);
        chk({28'h0, pwm_oe}, 32'h0);
        overcurrent_fault <= 4'h0;
        wait_mode(MPSS_PWM_SWITCH);
        chk(32'(n >= 2043 && n <= 2053), 32'h1);
        cyc(2060);
        st(MPSS_RUN);
        apb(0, `MPSS_STATUS_OFS, 32'h0, 32'he0);
        chk({31'h0, output_window_ok}, 32'h1);
        $display("test current trip done");
        undervoltage_fault <= 1;
        apb(1, `MPSS_CTRL_OFS, 32'h2);
        undervoltage_fault <= 0;
        apb(1, `MPSS_CTRL_OFS, 32'h3);
        for (int k = 1; k <= 8; k++) begin
            wait_mode(MPSS_PWM_SWITCH);
            overcurrent_fault <= 4'h1 << ($urandom % 4);
            cyc(3);
            overcurrent_fault <= 4'h0;
            chk({28'h0, pwm_oe}, 32'h0);
        end
        cyc(2100);
        chk({30'h0, pwm_mode}, {30'h0, MPSS_PWM_HIZ});
        chk({31'h0, output_window_ok}, 32'h0);
        st(MPSS_OC_LATCH);
        apb(1, `MPSS_CTRL_OFS, 32'h1);
        cyc(3);
        st(MPSS_SHUTDOWN);
        $display("test latch off done");
        results();
    end

    // the whole sequence needs about 30000 edges; this leaves ample margin
    initial begin
        cyc(80000);
        failures++;
        results();
    end
endmodule : mpss_sequencer_test
